//--- eep_pkg.sv
// constants and types for the two-wire serial memory slave front end
// Contract
// - array depth 4096, 8192 or 16384 bytes
// - operation: start, select byte, ack slot
// - ack driven in ninth slot after written bytes
// - bits shifted only by serial clock
// - serial data driven low or released only
// - straps compared with select bits b3..b1
// - write protect high blocks array writes
// - unconnected write protect reads as low
// - protected: select/address acked, data not acked
// - power-on clear holds standby, ignores bus
// - power-on clear again resets immediately
// - stop enters standby unless write running
// - select: msb first, type, straps, direction
// - sixteen-bit address from two bytes
// - always slave, never drives serial clock
// - start: data falls while clock high
// - watch for start except while writing
// - stop: data rises while clock high
// - read nack then stop gives standby
// - stop after write launches write cycle
// - strap mismatch: no ack, back to standby
// - write starts only on stop in slot ten
// - during write: output off, bus ignored
// - data sampled on serial clock rising edge
package eep_pkg;

	localparam int DEPTH_SMALL = 4096;
	localparam int DEPTH_MEDIUM = 8192;
	localparam int DEPTH_LARGE = 16384;
	localparam int PAGE_BYTES_DEFAULT = 32;
	localparam int WRITE_CYCLE_COUNT_DEFAULT = 1000;

	// value is arbitrary, not a real device type code
	localparam logic [3:0] DEVICE_TYPE_DEFAULT = 4'h5;

	localparam int SEL_RW_POS = 0;
	localparam int SEL_CS_LSB = 1;
	localparam int SEL_CS_MSB = 3;
	localparam int SEL_TYPE_LSB = 4;
	localparam int SEL_TYPE_MSB = 7;

	localparam logic [3:0] SLOT_LAST_BIT = 4'h7;
	localparam logic [3:0] SLOT_ACK = 4'h8;
	localparam logic [3:0] SLOT_RELEASE = 4'h9;
	localparam logic [3:0] SLOT_FIRST = 4'h0;

	localparam int PIN_COUNT = 7;
	// bit order: toggle, strap2, strap1, strap0, protect, data, clock
	localparam logic [6:0] PIN_RESET = 7'h03;
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_WP = 2;
	localparam int PIN_CS_LSB = 3;
	localparam int PIN_CS_MSB = 5;
	localparam int PIN_TOGGLE = 6;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_SELECT,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_BUSY
	} eep_state_type;

endpackage : eep_pkg

//--- eep_serial_slave.sv
// two-wire serial memory slave: bus decode, array, page buffer, write timer
`timescale 1ns/1ps
module eep_serial_slave
#(
	parameter int DEPTH = eep_pkg::DEPTH_SMALL,
	parameter int PAGE_BYTES = eep_pkg::PAGE_BYTES_DEFAULT,
	parameter int WRITE_CYCLE_COUNT = eep_pkg::WRITE_CYCLE_COUNT_DEFAULT,
	parameter logic [3:0] DEVICE_TYPE_CODE = eep_pkg::DEVICE_TYPE_DEFAULT
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic chip_select_strap_0,
	input wire logic chip_select_strap_1,
	input wire logic chip_select_strap_2,
	input wire logic write_protect_input,
	output logic standby,
	output logic write_busy
);

	localparam int AW = $clog2(DEPTH);
	localparam int PCW = $clog2(PAGE_BYTES + 1);
	localparam int PIW = $clog2(PAGE_BYTES);
	localparam int TW = $clog2(WRITE_CYCLE_COUNT + 1);

	logic link_bit;
	logic link_toggle;
	logic [eep_pkg::PIN_COUNT-1:0] pin_raw;
	logic [eep_pkg::PIN_COUNT-1:0] pin_s1;
	logic [eep_pkg::PIN_COUNT-1:0] pin_s2;
	logic [eep_pkg::PIN_COUNT-1:0] pin_s3;
	logic [eep_pkg::PIN_COUNT-1:0] pin_f;
	logic scl_q;
	logic sda_q;
	logic tog_q;
	logic scl_f;
	logic sda_f;
	logic wp_f;
	logic [2:0] strap_f;
	logic start_ev;
	logic stop_ev;
	logic fall_ev;
	logic bit_ev;

	eep_pkg::eep_state_type state;
	eep_pkg::eep_state_type next_st;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] next_byte;
	logic [7:0] tx;
	logic ack_go;
	logic master_ack;
	logic data_acked;
	logic [15:0] addr;
	logic [PCW-1:0] page_cnt;
	logic [PCW-1:0] commit_idx;
	logic [TW-1:0] timer;
	logic byte_done;
	logic wdata_take;
	logic commit_en;
	logic [AW-1:0] commit_addr;
	logic [AW-1:0] read_addr;

	logic [7:0] mem [DEPTH];
	logic [7:0] page_buf [PAGE_BYTES];

	// link side: data bit taken on the rising clock edge only
	always_ff @(posedge scl or posedge rst)
	begin
		if (rst)
		begin
			link_bit <= 1'b0;
			link_toggle <= 1'b0;
		end
		else
		begin
			link_bit <= sda_in;
			link_toggle <= ~link_toggle;
		end
	end

	// only the toggle crosses; link_bit holds until the next clock rise
	assign pin_raw = {link_toggle, chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
		write_protect_input, sda_in, scl};

	// three stages; a change counts once the last two agree
	genvar gi;
	generate
		for (gi = 0; gi < eep_pkg::PIN_COUNT; gi++)
		begin : g_pin
			always_ff @(posedge ref_clk or posedge rst)
			begin
				if (rst)
				begin
					pin_s1[gi] <= eep_pkg::PIN_RESET[gi];
					pin_s2[gi] <= eep_pkg::PIN_RESET[gi];
					pin_s3[gi] <= eep_pkg::PIN_RESET[gi];
					pin_f[gi] <= eep_pkg::PIN_RESET[gi];
				end
				else
				begin
					pin_s1[gi] <= pin_raw[gi];
					pin_s2[gi] <= pin_s1[gi];
					pin_s3[gi] <= pin_s2[gi];
					if (pin_s2[gi] == pin_s3[gi])
					begin
						pin_f[gi] <= pin_s2[gi];
					end
				end
			end
		end
	endgenerate

	assign scl_f = pin_f[eep_pkg::PIN_SCL];
	assign sda_f = pin_f[eep_pkg::PIN_SDA];
	// reset value low, so a protect pin that never drives reads as low
	assign wp_f = pin_f[eep_pkg::PIN_WP];
	assign strap_f = pin_f[eep_pkg::PIN_CS_MSB:eep_pkg::PIN_CS_LSB];

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			tog_q <= 1'b0;
		end
		else
		begin
			scl_q <= scl_f;
			sda_q <= sda_f;
			tog_q <= pin_f[eep_pkg::PIN_TOGGLE];
		end
	end

	assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_ev = scl_f & scl_q & ~sda_q & sda_f;
	assign fall_ev = scl_q & ~scl_f;
	// link_bit is stable for a whole clock high time, long after the toggle lands
	assign bit_ev = pin_f[eep_pkg::PIN_TOGGLE] ^ tog_q;

	assign next_byte = {shreg[6:0], link_bit};
	assign byte_done = bit_ev & (bit_cnt == eep_pkg::SLOT_LAST_BIT) & (state != eep_pkg::ST_RDATA)
		& (state != eep_pkg::ST_IDLE) & (state != eep_pkg::ST_BUSY) & ~start_ev & ~stop_ev;
	// protected data is neither buffered nor acked
	assign wdata_take = byte_done & (state == eep_pkg::ST_WDATA) & ~wp_f
		& (page_cnt < PCW'(PAGE_BYTES));
	// a reset mid-cycle drops the rest of the page; committed bytes stay
	assign commit_en = (state == eep_pkg::ST_BUSY) & (commit_idx < page_cnt);
	assign commit_addr = addr[AW-1:0] + AW'(commit_idx);
	assign read_addr = addr[AW-1:0];

	always_ff @(posedge ref_clk)
	begin
		if (wdata_take)
		begin
			page_buf[page_cnt[PIW-1:0]] <= next_byte;
		end
	end

	// bytes reach the array only inside the write cycle, one per clock
	always_ff @(posedge ref_clk)
	begin
		if (commit_en)
		begin
			mem[commit_addr] <= page_buf[commit_idx[PIW-1:0]];
		end
	end

	// protocol engine; rst doubles as the power-on clear
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			state <= eep_pkg::ST_IDLE;
			next_st <= eep_pkg::ST_IDLE;
			bit_cnt <= eep_pkg::SLOT_FIRST;
			shreg <= 8'h00;
			tx <= 8'h00;
			ack_go <= 1'b0;
			master_ack <= 1'b0;
			data_acked <= 1'b0;
			addr <= 16'h0000;
			page_cnt <= '0;
			commit_idx <= '0;
			timer <= '0;
			sda_oe <= 1'b0;
		end
		else if (state == eep_pkg::ST_BUSY)
		begin
			// bus is not watched at all until the cycle ends
			sda_oe <= 1'b0;
			if (commit_en)
			begin
				commit_idx <= commit_idx + PCW'(1);
			end
			if (timer == TW'(WRITE_CYCLE_COUNT - 1))
			begin
				state <= eep_pkg::ST_IDLE;
				addr <= addr + 16'(page_cnt);
				page_cnt <= '0;
			end
			else
			begin
				timer <= timer + TW'(1);
			end
		end
		else if (start_ev)
		begin
			state <= eep_pkg::ST_SELECT;
			bit_cnt <= eep_pkg::SLOT_FIRST;
			ack_go <= 1'b0;
			data_acked <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (stop_ev)
		begin
			sda_oe <= 1'b0;
			bit_cnt <= eep_pkg::SLOT_FIRST;
			// the tenth slot has seen exactly its one clock rise by now
			if ((state == eep_pkg::ST_WDATA) && (bit_cnt == (eep_pkg::SLOT_FIRST + 4'h1)) && data_acked
				&& (page_cnt != '0))
			begin
				state <= eep_pkg::ST_BUSY;
				timer <= '0;
				commit_idx <= '0;
			end
			else
			begin
				state <= eep_pkg::ST_IDLE;
			end
		end
		else if (state != eep_pkg::ST_IDLE)
		begin
			if (bit_ev)
			begin
				if (bit_cnt == eep_pkg::SLOT_ACK)
				begin
					bit_cnt <= eep_pkg::SLOT_RELEASE;
					master_ack <= ~link_bit;
					if ((state == eep_pkg::ST_RDATA) && !link_bit)
					begin
						addr <= addr + 16'h0001;
					end
				end
				else if (bit_cnt < eep_pkg::SLOT_ACK)
				begin
					shreg <= next_byte;
					bit_cnt <= bit_cnt + 4'h1;
					// a stop needs one clock rise first, so the ack mark survives it
					if (bit_cnt != eep_pkg::SLOT_FIRST)
					begin
						data_acked <= 1'b0;
					end
				end
				if (byte_done)
				begin
					case (state)
						eep_pkg::ST_SELECT:
						begin
							if ((next_byte[eep_pkg::SEL_TYPE_MSB:eep_pkg::SEL_TYPE_LSB] == DEVICE_TYPE_CODE)
								&& (next_byte[eep_pkg::SEL_CS_MSB:eep_pkg::SEL_CS_LSB] == strap_f))
							begin
								ack_go <= 1'b1;
								next_st <= next_byte[eep_pkg::SEL_RW_POS] ? eep_pkg::ST_RDATA
									: eep_pkg::ST_ADDR_HI;
							end
							else
							begin
								ack_go <= 1'b0;
								state <= eep_pkg::ST_IDLE;
							end
						end
						eep_pkg::ST_ADDR_HI:
						begin
							addr[15:8] <= next_byte;
							ack_go <= 1'b1;
							next_st <= eep_pkg::ST_ADDR_LO;
						end
						eep_pkg::ST_ADDR_LO:
						begin
							addr[7:0] <= next_byte;
							ack_go <= 1'b1;
							page_cnt <= '0;
							next_st <= eep_pkg::ST_WDATA;
						end
						eep_pkg::ST_WDATA:
						begin
							ack_go <= ~wp_f;
							next_st <= eep_pkg::ST_WDATA;
							if (wdata_take)
							begin
								page_cnt <= page_cnt + PCW'(1);
							end
						end
						default:
						begin
							ack_go <= 1'b0;
							next_st <= eep_pkg::ST_IDLE;
						end
					endcase
				end
			end
			else if (fall_ev)
			begin
				if (bit_cnt == eep_pkg::SLOT_ACK)
				begin
					// reads release here so the master owns the ninth slot
					sda_oe <= (state != eep_pkg::ST_RDATA) & ack_go;
				end
				else if (bit_cnt == eep_pkg::SLOT_RELEASE)
				begin
					bit_cnt <= eep_pkg::SLOT_FIRST;
					if (state == eep_pkg::ST_RDATA)
					begin
						if (master_ack)
						begin
							tx <= mem[read_addr];
							sda_oe <= ~mem[read_addr][7];
						end
						else
						begin
							state <= eep_pkg::ST_IDLE;
							sda_oe <= 1'b0;
						end
					end
					else
					begin
						state <= next_st;
						data_acked <= (state == eep_pkg::ST_WDATA) & ack_go;
						if (next_st == eep_pkg::ST_RDATA)
						begin
							tx <= mem[read_addr];
							sda_oe <= ~mem[read_addr][7];
						end
						else
						begin
							sda_oe <= 1'b0;
						end
					end
				end
				else if ((state == eep_pkg::ST_RDATA) && (bit_cnt != eep_pkg::SLOT_FIRST))
				begin
					// data changes only while the clock is low
					sda_oe <= ~tx[3'(4'h7 - bit_cnt)];
				end
			end
		end
	end

	// the pin only ever pulls low; no clock output exists
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sda_out <= 1'b0;
			standby <= 1'b1;
			write_busy <= 1'b0;
		end
		else
		begin
			sda_out <= 1'b0;
			standby <= (state == eep_pkg::ST_IDLE);
			write_busy <= (state == eep_pkg::ST_BUSY);
		end
	end

endmodule : eep_serial_slave

//--- eep_master_model.sv
// two-wire bus master model for the serial memory slave
`timescale 1ns/1ps
module eep_master_model
(
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	localparam time H = 300ns;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic start();
		sda_low = 1'b0;
		#H scl = 1'b1;
		#H sda_low = 1'b1;
		#H scl = 1'b0;
	endtask : start
	// nine bits msb first, data moves only with clock low
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			sda_low = !d[i];
			#H scl = 1'b1;
			q[i] = sda;
			#H scl = 1'b0;
		end
	endtask : xfer
	task automatic stop();
		sda_low = 1'b1;
		#H scl = 1'b1;
		#H sda_low = 1'b0;
		#H;
	endtask : stop
endmodule : eep_master_model

//--- eep_serial_slave_chk.sv
// port checks for the serial memory slave
`timescale 1ns/1ps
module eep_serial_slave_chk
#(
	parameter int WRITE_CYCLE_COUNT = 1000
)
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic standby,
	input wire logic write_busy
);
	int busy_len;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	// long write cycle too slow to unroll, so count it
	always_ff @(posedge ref_clk or posedge rst)
		if (rst)
			busy_len <= 0;
		else if (write_busy)
			busy_len <= busy_len + 1;
		else
			busy_len <= 0;
	reset_idle_a: assert property (disable iff (1'b0) rst |-> standby && !write_busy && !sda_oe)
		else $error("outputs not idle in reset");
	drive_low_a: assert property (!sda_out)
		else $error("data output not low");
	edge_timed_a: assert property ($changed(sda_oe) |-> !scl)
		else $error("data drive moved with clock high");
	busy_quiet_a: assert property (write_busy |-> !sda_oe)
		else $error("data driven while busy");
	busy_active_a: assert property (write_busy |-> !standby)
		else $error("standby while busy");
	busy_len_a: assert property ($fell(write_busy) |-> busy_len == WRITE_CYCLE_COUNT)
		else $error("write cycle length wrong");
	busy_on_stop_a: assert property ($rose(write_busy) |-> scl && sda_in)
		else $error("write cycle without stop");
	busy_end_idle_a: assert property ($fell(write_busy) |-> ##[0:2] standby)
		else $error("no standby after write cycle");
	idle_quiet_a: assert property (standby [*2] |-> !sda_oe)
		else $error("data driven in standby");
	cover property ($rose(write_busy));
	cover property ($rose(sda_oe));
	cover property (scl && $fell(standby));
endmodule : eep_serial_slave_chk
bind eep_serial_slave eep_serial_slave_chk #(.WRITE_CYCLE_COUNT(WRITE_CYCLE_COUNT)) chk_i
(
	.ref_clk(ref_clk),
	.rst(rst),
	.scl(scl),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.standby(standby),
	.write_busy(write_busy)
);

//--- tb_eep_serial_slave.sv
// self-checking bench for the serial memory slave
`timescale 1ns/1ps
module tb_eep_serial_slave;
	logic ref_clk;
	logic rst;
	logic [2:0] cs;
	logic wp;
	logic scl;
	logic m_low;
	logic sda_out;
	logic sda_oe;
	logic standby;
	logic write_busy;
	logic [8:0] q;
	logic [7:0] mem [0:4095];
	logic [11:0] a;
	int fail_count;
	int n_compared;
	// pull-up wire, either side may pull low
	wire logic sda = !(m_low || (sda_oe && !sda_out));
	eep_serial_slave #(.WRITE_CYCLE_COUNT(2000)) eep_serial_slave_i
	(
		.ref_clk(ref_clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
		.chip_select_strap_0(cs[0]), .chip_select_strap_1(cs[1]), .chip_select_strap_2(cs[2]),
		.write_protect_input(wp), .standby(standby), .write_busy(write_busy)
	);
	eep_master_model eep_master_model_i (.scl(scl), .sda_low(m_low), .sda(sda));
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check
	function automatic logic [7:0] sel(input logic rd);
		return {eep_pkg::DEVICE_TYPE_DEFAULT, cs, rd};
	endfunction : sel
	task automatic wbyte(input logic [7:0] v, input logic ack, input string what);
		eep_master_model_i.xfer({v, 1'b1}, q);
		check(what, {7'h0, ack}, {7'h0, !q[0]});
	endtask : wbyte
	task automatic head(input logic [11:0] ad);
		eep_master_model_i.start();
		wbyte(sel(1'b0), 1'b1, "select ack");
		wbyte({4'h0, ad[11:8]}, 1'b1, "addr hi ack");
		wbyte(ad[7:0], 1'b1, "addr lo ack");
	endtask : head
	task automatic wr(input logic [11:0] ad, input logic [7:0] v0, input logic [7:0] v1, input logic prot);
		@(posedge ref_clk);
		#1 wp = prot;
		head(ad);
		wbyte(v0, !prot, "data ack");
		wbyte(v1, !prot, "data ack");
		eep_master_model_i.stop();
		check("busy after stop", {7'h0, !prot}, {7'h0, write_busy});
		if (!prot)
		begin
			mem[ad] = v0;
			mem[ad + 12'h1] = v1;
			eep_master_model_i.start();
			wbyte(sel(1'b0), 1'b0, "poll ack");
			eep_master_model_i.stop();
			for (int i = 0; i < 30000 && write_busy !== 1'b0; i++)
				@(posedge ref_clk);
			repeat (3) @(posedge ref_clk);
		end
		check("standby", 8'h01, {7'h0, standby});
	endtask : wr
	task automatic rd(input logic [11:0] ad);
		head(ad);
		eep_master_model_i.start();
		wbyte(sel(1'b1), 1'b1, "read select ack");
		eep_master_model_i.xfer(9'h1fe, q);
		check("read byte", mem[ad], q[8:1]);
		eep_master_model_i.xfer(9'h1ff, q);
		check("read next byte", mem[ad + 12'h1], q[8:1]);
		eep_master_model_i.stop();
		check("standby after read", 8'h01, {7'h0, standby});
	endtask : rd
	task automatic report_and_stop();
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	initial
	begin
		#800us;
		fail_count++;
		report_and_stop();
	end
	initial
	begin
		fail_count = 0;
		n_compared = 0;
		rst = 1'b1;
		wp = 1'b0; // low as if unconnected
		cs = 3'h0;
		void'($urandom(32'h1262));
		repeat (6) @(posedge ref_clk);
		#1 rst = 1'b0;
		repeat (5) @(posedge ref_clk);
		check("standby after reset", 8'h01, {7'h0, standby});
		head(12'hfff);
		eep_master_model_i.stop();
		check("busy after early stop", 8'h00, {7'h0, write_busy});
		for (int k = 0; k < 4; k++)
		begin
			@(posedge ref_clk);
			#1 cs = 3'($urandom);
			a = 12'($urandom);
			eep_master_model_i.start();
			wbyte({eep_pkg::DEVICE_TYPE_DEFAULT, cs ^ (3'h1 << (k % 3)), 1'b0}, 1'b0, "foreign ack");
			eep_master_model_i.stop();
			check("standby after foreign", 8'h01, {7'h0, standby});
			wr(a, 8'($urandom), 8'($urandom), 1'b0);
			wr(a, ~mem[a], ~mem[a + 12'h1], 1'b1);
			rd(a);
		end
		eep_master_model_i.start();
		wbyte(sel(1'b1), 1'b1, "read select ack");
		@(posedge ref_clk);
		#1 rst = 1'b1;
		@(posedge ref_clk);
		#1 check("drive in reset", 8'h00, {7'h0, sda_oe});
		check("standby in reset", 8'h01, {7'h0, standby});
		report_and_stop();
	end
endmodule : tb_eep_serial_slave
